/* File: include/pwr_seq_pkg.sv */
// Package with comparator flag indices, timing counts and mode enumeration for the power path sequencer
`default_nettype none
package pwr_seq_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned SYNC_STAGES = 2;
    // Wake timer default interval in ms, converted to cycles
    localparam int unsigned WAKE_MS = 1000;
    localparam int unsigned WAKE_CYCLES = WAKE_MS * (CLK_HZ / 1000);
    localparam int unsigned WAKE_W = 32;
    // Shutdown warning time before protection mode separates storages, in us
    localparam int unsigned WARN_US = 100;
    localparam int unsigned WARN_CYCLES = WARN_US * (CLK_HZ / 1_000_000);
    localparam int unsigned AUX_N = 3;
    // Index of each comparator flag within the synchronised bundle
    localparam int unsigned CMP_N = 11;
    localparam int unsigned C_HRV_OK = 0;
    localparam int unsigned C_STS_CS = 1;
    localparam int unsigned C_STS_GOOD_SEP = 2;
    localparam int unsigned C_STS_GOOD_JOIN = 3;
    localparam int unsigned C_STS_CEIL_LO = 4;
    localparam int unsigned C_STS_CEIL_HI = 5;
    localparam int unsigned C_LTS_GOOD_SEP = 6;
    localparam int unsigned C_LTS_PROT = 7;
    localparam int unsigned C_STOR_STOP = 8;
    localparam int unsigned C_STOR_RESUME = 9;
    localparam int unsigned C_WAKE = 10;
    typedef enum logic [2:0] {
        ST_COLD,
        ST_BOOT,
        ST_PROTECT,
        ST_NORMAL,
        ST_WARN,
        ST_SLEEP
    } mode_t;
endpackage : pwr_seq_pkg
`default_nettype wire

/* File: src/cmp_sync.sv */
// Two-stage synchroniser bank for analog comparator flags
`default_nettype none
module cmp_sync #(
    parameter int unsigned W = 11
) (
    input wire logic sys_clk, // Clock
    input wire logic rst, // Synchronous reset
    input wire logic [W-1:0] async_in, // Raw comparator flags
    output logic [W-1:0] sync_out // Synchronised flags
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    meta_q[i] <= 1'b0;
                    sync_q[i] <= 1'b0;
                end else begin
                    meta_q[i] <= async_in[i];
                    sync_q[i] <= meta_q[i];
                end
            end
        end
    endgenerate

    assign sync_out = sync_q;
endmodule : cmp_sync
`default_nettype wire

/* File: src/wake_timer.sv */
// Down counter that pulses once a programmed interval has elapsed
`default_nettype none
module wake_timer #(
    parameter int unsigned W = 32
) (
    input wire logic sys_clk, // Clock
    input wire logic rst, // Synchronous reset
    input wire logic start, // Load and run, pulse
    input wire logic stop, // Abort, level
    input wire logic [W-1:0] interval, // Cycles to wait
    output logic expired // One-cycle pulse on expiry
);
    logic [W-1:0] cnt_q;
    logic run_q;
    logic expired_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt_q <= '0;
            run_q <= 1'b0;
            expired_q <= 1'b0;
        end else begin
            expired_q <= 1'b0;
            if (stop) begin
                run_q <= 1'b0;
            end else if (start) begin
                cnt_q <= (interval == '0) ? W'(1) : interval;
                run_q <= 1'b1;
            end else if (run_q) begin
                if (cnt_q == W'(1)) begin
                    run_q <= 1'b0;
                    expired_q <= 1'b1;
                end
                cnt_q <= cnt_q - W'(1);
            end
        end
    end

    assign expired = expired_q;
endmodule : wake_timer
`default_nettype wire

/* File: src/power_path_seq.sv */
// Mode sequencer for a dual-storage harvesting power manager
// Operation
// - Long-term storage under protection level: protection mode, storages separated, battery-low high
// - Protection mode: outputs fed only from converter path, long-term storage isolated
// - Normal mode keeps storages joined; aux outputs and grounds may be switched off
// - Sleep removes main output; wake pin or timer restores it
// - Short-term minimum good comparison uses separated or joined level by connection state
// - Cold start charges short-term storage; past cold-start level boot and track power
// - Short-term above minimum good level connects main output
// - Short-term at application ceiling lower redirects converter to long-term storage
// - Short-term back at minimum good level redirects converter to short-term storage
// - Long-term above minimum good level joins storages, battery-low low
// - Charged battery start: join immediately, boot at cold-start level, connect main; join here waits until boot enters normal mode
// - At application ceiling main output goes through regulator, from start if above
// - Both storages at charge stop level stop converter
// - Converter restarts at charge resume level after over-voltage stop
// - Converter gated by harvester minimum; harvester-low indicator shows weak harvester
// - Auxiliary outputs follow main output enable and regulation
// - Battery-low warning first, then application shutdown sequence; from sleep, protection mode is entered without the warning phase
// - Timed wake-up re-enables main output after configured interval
// - Auxiliary ground returns can be opened
// - Thresholds fixed by external comparator flags; host programs only wake interval, 0 uses default
// - All digital indicator and interface pins active high
`default_nettype none
module power_path_seq #(
    parameter int unsigned AUX_N = pwr_seq_pkg::AUX_N,
    parameter logic [pwr_seq_pkg::WAKE_W-1:0] WAKE_CYCLES = pwr_seq_pkg::WAKE_W'(pwr_seq_pkg::WAKE_CYCLES),
    parameter int unsigned WARN_CYCLES = pwr_seq_pkg::WARN_CYCLES
) (
    input wire logic sys_clk, // 50 MHz clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic hrv_above_min, // Harvester above minimum
    input wire logic sts_above_cold_start, // Short-term above cold-start end level
    input wire logic sts_above_good_sep, // Short-term above minimum good level separated
    input wire logic sts_above_good_join, // Short-term above minimum good level joined
    input wire logic sts_at_ceiling_lower, // Short-term at application ceiling lower
    input wire logic sts_at_ceiling_upper, // Storage at application ceiling upper
    input wire logic lts_above_good_sep, // Long-term above minimum good level
    input wire logic lts_below_protection, // Long-term below protection entry level
    input wire logic stor_at_charge_stop, // Both storages at charge stop level
    input wire logic stor_at_charge_resume, // Both storages down to charge resume level
    input wire logic wake_up, // Wake-up pin
    input wire logic sleep_req, // Host sleep request, level
    input wire logic timed_wake_en, // Enable timed wake-up
    input wire logic [pwr_seq_pkg::WAKE_W-1:0] wake_interval, // Wake interval in cycles, 0 uses default
    input wire logic [AUX_N-1:0] aux_off_cfg, // Switch off aux output in normal mode
    input wire logic [AUX_N-1:0] aux_gnd_off_cfg, // Open aux ground return in normal mode
    output logic converter_en, // Boost converter running
    output logic charge_to_lts, // Converter output routed to long-term storage
    output logic tracking_en, // Power-point tracking active
    output logic storage_join, // Long-term and short-term storage joined
    output logic main_output_en, // Main output enabled
    output logic main_output_reg, // Main output through regulator
    output logic [AUX_N-1:0] aux_output_en, // Auxiliary output enables
    output logic [AUX_N-1:0] aux_output_reg, // Auxiliary output regulated
    output logic [AUX_N-1:0] aux_gnd_en, // Auxiliary ground returns closed
    output logic battery_low, // Battery-low indicator, active high
    output logic harvester_low, // Harvester-low indicator, active high
    output logic [2:0] mode_state // Current mode for status
);
    ////////////////////////////////////////////////////////////////////////////////
    // Comparator synchronisation
    logic [pwr_seq_pkg::CMP_N-1:0] raw_flags;
    logic [pwr_seq_pkg::CMP_N-1:0] f;

    assign raw_flags = {wake_up, stor_at_charge_resume, stor_at_charge_stop, lts_below_protection,
                        lts_above_good_sep, sts_at_ceiling_upper, sts_at_ceiling_lower,
                        sts_above_good_join, sts_above_good_sep, sts_above_cold_start, hrv_above_min};

    cmp_sync #(.W(pwr_seq_pkg::CMP_N)) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in(raw_flags),
        .sync_out(f)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // State
    pwr_seq_pkg::mode_t state_q;
    pwr_seq_pkg::mode_t state_d;
    logic join_q;
    logic to_lts_q;
    logic ov_stop_q;
    logic main_on_q;
    logic reg_q;
    logic bat_low_q;
    logic hrv_low_q;
    logic [31:0] warn_cnt_q;
    logic timer_start;
    logic timer_exp;
    logic sts_good;
    logic lts_good;

    // Threshold selection by connection state
    assign sts_good = join_q ? f[pwr_seq_pkg::C_STS_GOOD_JOIN] : f[pwr_seq_pkg::C_STS_GOOD_SEP];
    assign lts_good = f[pwr_seq_pkg::C_LTS_GOOD_SEP];

    ////////////////////////////////////////////////////////////////////////////////
    // Mode transitions
    always_comb begin
        state_d = state_q;
        case (state_q)
            pwr_seq_pkg::ST_COLD: begin
                if (f[pwr_seq_pkg::C_STS_CS]) begin
                    state_d = pwr_seq_pkg::ST_BOOT;
                end
            end
            pwr_seq_pkg::ST_BOOT: begin
                if (lts_good && !f[pwr_seq_pkg::C_LTS_PROT]) begin
                    state_d = pwr_seq_pkg::ST_NORMAL;
                end else begin
                    state_d = pwr_seq_pkg::ST_PROTECT;
                end
            end
            pwr_seq_pkg::ST_PROTECT: begin
                if (!f[pwr_seq_pkg::C_STS_CS] && !main_on_q) begin
                    state_d = pwr_seq_pkg::ST_COLD;
                end else if (lts_good) begin
                    state_d = pwr_seq_pkg::ST_NORMAL;
                end
            end
            pwr_seq_pkg::ST_NORMAL: begin
                if (f[pwr_seq_pkg::C_LTS_PROT]) begin
                    state_d = pwr_seq_pkg::ST_WARN;
                end else if (sleep_req) begin
                    state_d = pwr_seq_pkg::ST_SLEEP;
                end
            end
            pwr_seq_pkg::ST_WARN: begin
                if (warn_cnt_q >= WARN_CYCLES - 1) begin
                    state_d = pwr_seq_pkg::ST_PROTECT;
                end
            end
            pwr_seq_pkg::ST_SLEEP: begin
                if (f[pwr_seq_pkg::C_LTS_PROT]) begin
                    state_d = pwr_seq_pkg::ST_PROTECT;
                end else if (f[pwr_seq_pkg::C_WAKE] || timer_exp) begin
                    state_d = pwr_seq_pkg::ST_NORMAL;
                end
            end
            default: state_d = pwr_seq_pkg::ST_COLD;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= pwr_seq_pkg::ST_COLD;
        end else begin
            state_q <= state_d;
        end
    end

    // Warning dwell counter
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            warn_cnt_q <= '0;
        end else if (state_q == pwr_seq_pkg::ST_WARN) begin
            warn_cnt_q <= warn_cnt_q + 32'd1;
        end else begin
            warn_cnt_q <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Storage joining and converter routing
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            join_q <= 1'b0;
        end else if (state_d == pwr_seq_pkg::ST_PROTECT || state_d == pwr_seq_pkg::ST_COLD) begin
            join_q <= 1'b0;
        end else if (state_d == pwr_seq_pkg::ST_NORMAL || state_d == pwr_seq_pkg::ST_SLEEP
                     || state_d == pwr_seq_pkg::ST_WARN) begin
            join_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            to_lts_q <= 1'b0;
        end else if (state_d != pwr_seq_pkg::ST_PROTECT) begin
            to_lts_q <= 1'b0;
        end else if (f[pwr_seq_pkg::C_STS_CEIL_LO]) begin
            to_lts_q <= 1'b1;
        end else if (!sts_good) begin
            to_lts_q <= 1'b0;
        end
    end

    // Over-voltage charge stop hysteresis
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ov_stop_q <= 1'b0;
        end else if (f[pwr_seq_pkg::C_STOR_STOP]) begin
            ov_stop_q <= 1'b1;
        end else if (f[pwr_seq_pkg::C_STOR_RESUME]) begin
            ov_stop_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output enables and regulation
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            main_on_q <= 1'b0;
        end else begin
            case (state_d)
                pwr_seq_pkg::ST_COLD,
                pwr_seq_pkg::ST_BOOT: main_on_q <= 1'b0;
                pwr_seq_pkg::ST_SLEEP: main_on_q <= 1'b0;
                pwr_seq_pkg::ST_PROTECT: begin
                    if (sts_good) begin
                        main_on_q <= 1'b1;
                    end else if (!f[pwr_seq_pkg::C_STS_CS]) begin
                        main_on_q <= 1'b0;
                    end
                end
                default: main_on_q <= 1'b1;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_q <= 1'b0;
        end else if (f[pwr_seq_pkg::C_STS_CEIL_HI]) begin
            reg_q <= 1'b1;
        end else if (!f[pwr_seq_pkg::C_STS_CEIL_LO]) begin
            reg_q <= 1'b0;
        end
    end

    // Indicators
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bat_low_q <= 1'b1;
        end else if (state_d == pwr_seq_pkg::ST_WARN || state_d == pwr_seq_pkg::ST_PROTECT
                     || state_d == pwr_seq_pkg::ST_COLD) begin
            bat_low_q <= 1'b1;
        end else if (state_d == pwr_seq_pkg::ST_NORMAL) begin
            bat_low_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hrv_low_q <= 1'b1;
        end else begin
            hrv_low_q <= !f[pwr_seq_pkg::C_HRV_OK];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Timed wake-up
    assign timer_start = timed_wake_en && state_q == pwr_seq_pkg::ST_NORMAL
                         && state_d == pwr_seq_pkg::ST_SLEEP;

    wake_timer #(.W(pwr_seq_pkg::WAKE_W)) u_wake (
        .sys_clk(sys_clk),
        .rst(rst),
        .start(timer_start),
        .stop(state_q != pwr_seq_pkg::ST_SLEEP && !timer_start),
        .interval((wake_interval == '0) ? WAKE_CYCLES : wake_interval),
        .expired(timer_exp)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Output drive
    assign converter_en = f[pwr_seq_pkg::C_HRV_OK] && !ov_stop_q;
    assign charge_to_lts = to_lts_q;
    assign tracking_en = converter_en && state_q != pwr_seq_pkg::ST_COLD;
    assign storage_join = join_q;
    assign main_output_en = main_on_q;
    assign main_output_reg = main_on_q && reg_q;
    assign battery_low = bat_low_q;
    assign harvester_low = hrv_low_q;
    assign mode_state = state_q;

    genvar a;
    generate
        for (a = 0; a < AUX_N; a++) begin : g_aux
            logic normal_off;
            assign normal_off = state_q == pwr_seq_pkg::ST_NORMAL;
            assign aux_output_en[a] = main_on_q && !(normal_off && aux_off_cfg[a]);
            assign aux_output_reg[a] = main_output_reg;
            assign aux_gnd_en[a] = main_on_q && !(normal_off && aux_gnd_off_cfg[a]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions
    AST_PROT_SEPARATE: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == pwr_seq_pkg::ST_PROTECT |-> !storage_join && battery_low)
        else $error("protection mode with storage joined or battery-low clear");
    AST_NORMAL_JOIN: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == pwr_seq_pkg::ST_NORMAL |-> storage_join && !battery_low)
        else $error("normal mode without join");
    AST_SLEEP_OFF: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == pwr_seq_pkg::ST_SLEEP |-> !main_output_en)
        else $error("main output on in sleep");
    AST_OV_STOP: assert property (@(posedge sys_clk) disable iff (rst)
        f[pwr_seq_pkg::C_STOR_STOP] |=> !converter_en)
        else $error("converter running after charge stop");
    AST_OV_RESUME: assert property (@(posedge sys_clk) disable iff (rst)
        f[pwr_seq_pkg::C_STOR_RESUME] && !f[pwr_seq_pkg::C_STOR_STOP] && f[pwr_seq_pkg::C_HRV_OK]
        && $stable(f[pwr_seq_pkg::C_HRV_OK]) |=> converter_en == f[pwr_seq_pkg::C_HRV_OK])
        else $error("converter not restarted");
    AST_HRV_LOW: assert property (@(posedge sys_clk) disable iff (rst)
        !f[pwr_seq_pkg::C_HRV_OK] |=> harvester_low)
        else $error("harvester-low not raised");
    AST_AUX_FOLLOW: assert property (@(posedge sys_clk) disable iff (rst)
        !main_output_en |-> aux_output_en == '0)
        else $error("aux output on with main off");
    AST_WARN_DWELL: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(state_q == pwr_seq_pkg::ST_WARN) |-> battery_low ##1 state_q == pwr_seq_pkg::ST_WARN)
        else $error("warning phase too short");
    AST_REG_MAIN: assert property (@(posedge sys_clk) disable iff (rst)
        main_output_en && f[pwr_seq_pkg::C_STS_CEIL_HI] |=> main_output_reg || !main_output_en)
        else $error("main output not regulated at ceiling");
    AST_COLD_EXIT: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == pwr_seq_pkg::ST_COLD && f[pwr_seq_pkg::C_STS_CS] |=> state_q == pwr_seq_pkg::ST_BOOT)
        else $error("cold start not finished");
    AST_CHARGE_SEP: assert property (@(posedge sys_clk) disable iff (rst)
        charge_to_lts |-> !storage_join)
        else $error("converter routed to long-term storage while joined");
    AST_SLEEP_PROT: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == pwr_seq_pkg::ST_SLEEP && f[pwr_seq_pkg::C_LTS_PROT] |=> state_q == pwr_seq_pkg::ST_PROTECT)
        else $error("sleep not left on protection flag");
    AST_WARN_MAIN: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == pwr_seq_pkg::ST_WARN |-> main_output_en && battery_low)
        else $error("outputs dropped before warning ended");

    // Cover points for main scenarios
    COV_NORMAL: cover property (@(posedge sys_clk) disable iff (rst) state_q == pwr_seq_pkg::ST_NORMAL);
    COV_SLEEP_PROT: cover property (@(posedge sys_clk) disable iff (rst)
        state_q == pwr_seq_pkg::ST_SLEEP ##1 state_q == pwr_seq_pkg::ST_PROTECT);
    COV_OV_RESUME: cover property (@(posedge sys_clk) disable iff (rst) $fell(ov_stop_q));
    COV_WAKE_TIMER: cover property (@(posedge sys_clk) disable iff (rst)
        state_q == pwr_seq_pkg::ST_SLEEP && timer_exp);
    COV_TO_LTS: cover property (@(posedge sys_clk) disable iff (rst) charge_to_lts);
endmodule : power_path_seq
`default_nettype wire

/* File: testbench/storage_cmp_model.sv */
// Comparator model of harvester and storage voltages
`default_nettype none
module storage_cmp_model #(
    parameter int HRV_MIN = 200, CS = 1300, GOOD_SEP = 2800, GOOD_JOIN = 3000,
    parameter int CEIL_LO = 3300, CEIL_HI = 3500, PROT = 2500, STOP = 4100, RESUME = 4000
) (
    input var int hrv_mv, // Harvester in mV
    input var int sts_mv, // Short-term storage in mV
    input var int lts_mv, // Long-term storage in mV
    output logic [9:0] flags // Comparator levels
);
    assign flags[0] = hrv_mv > HRV_MIN;
    assign flags[1] = sts_mv > CS;
    assign flags[2] = sts_mv > GOOD_SEP;
    assign flags[3] = sts_mv > GOOD_JOIN;
    assign flags[4] = sts_mv >= CEIL_LO;
    assign flags[5] = sts_mv >= CEIL_HI;
    assign flags[6] = lts_mv > GOOD_SEP;
    assign flags[7] = lts_mv < PROT;
    assign flags[8] = sts_mv >= STOP && lts_mv >= STOP;
    assign flags[9] = sts_mv <= RESUME && lts_mv <= RESUME;
endmodule : storage_cmp_model
`default_nettype wire

/* File: testbench/power_path_seq_tb_top.sv */
// Self-checking bench for the power path sequencer
`default_nettype none
module power_path_seq_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, rst, wake_up, sleep_req, timed_wake_en, converter_en, charge_to_lts, tracking_en;
    logic storage_join, main_output_en, main_output_reg, battery_low, harvester_low;
    logic [31:0] wake_interval;
    logic [2:0] aux_off_cfg, aux_gnd_off_cfg, aux_output_en, aux_output_reg, aux_gnd_en, mode_state;
    logic [9:0] cmp;
    int h, s, l, errors, checked, n;
    storage_cmp_model i_cmp (.hrv_mv(h), .sts_mv(s), .lts_mv(l), .flags(cmp));
    power_path_seq #(.WAKE_CYCLES(32'h0000_0040), .WARN_CYCLES(8)) i_dut (
        .sys_clk(sys_clk), .rst(rst), .hrv_above_min(cmp[0]), .sts_above_cold_start(cmp[1]),
        .sts_above_good_sep(cmp[2]), .sts_above_good_join(cmp[3]), .sts_at_ceiling_lower(cmp[4]),
        .sts_at_ceiling_upper(cmp[5]), .lts_above_good_sep(cmp[6]), .lts_below_protection(cmp[7]),
        .stor_at_charge_stop(cmp[8]), .stor_at_charge_resume(cmp[9]), .wake_up(wake_up),
        .sleep_req(sleep_req), .timed_wake_en(timed_wake_en), .wake_interval(wake_interval),
        .aux_off_cfg(aux_off_cfg), .aux_gnd_off_cfg(aux_gnd_off_cfg), .converter_en(converter_en),
        .charge_to_lts(charge_to_lts), .tracking_en(tracking_en), .storage_join(storage_join),
        .main_output_en(main_output_en), .main_output_reg(main_output_reg), .aux_output_en(aux_output_en),
        .aux_output_reg(aux_output_reg), .aux_gnd_en(aux_gnd_en), .battery_low(battery_low),
        .harvester_low(harvester_low), .mode_state(mode_state)
    );
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        if (errors == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic step(input int k);
        repeat (k) @(posedge sys_clk);
        #2;
    endtask : step
    task automatic volts(input int hv, input int sv, input int lv);
        h = hv;
        s = sv;
        l = lv;
        step(4);
    endtask : volts
    task automatic wait_mode(input logic [2:0] m, input int bound);
        n = 0;
        while (mode_state !== m) begin
            if (n == bound) begin
                check("mode_state", mode_state, m);
                conclude();
            end
            step(1);
            n++;
        end
    endtask : wait_mode
    task automatic do_reset();
        rst = 1'b1;
        step(5);
        rst = 1'b0;
    endtask : do_reset
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check("mode", mode_state, pwr_seq_pkg::ST_COLD);
        check("join", storage_join, 1'b0);
        check("main", main_output_en, 1'b0);
        check("bat_low", battery_low, 1'b1);
        check("hrv_low", harvester_low, 1'b1);
        check("conv", converter_en, 1'b0);
        h = 500;
        step(1);
        check("conv", converter_en, 1'b0);
        step(3);
        check("conv", converter_en, 1'b1);
        check("hrv_low", harvester_low, 1'b0);
    endtask : t_reset
    task automatic t_cold_start();
        s = 1500;
        wait_mode(pwr_seq_pkg::ST_PROTECT, 10);
        step(1);
        check("track", tracking_en, 1'b1);
        check("join", storage_join, 1'b0);
        check("bat_low", battery_low, 1'b1);
        volts(500, 2900, 0);
        check("main", main_output_en, 1'b1);
        check("aux", aux_output_en, 3'h7);
        volts(500, 3400, 0);
        check("to_lts", charge_to_lts, 1'b1);
        volts(500, 2700, 0);
        check("to_lts", charge_to_lts, 1'b0);
    endtask : t_cold_start
    task automatic t_normal();
        volts(500, 2900, 3100);
        check("mode", mode_state, pwr_seq_pkg::ST_NORMAL);
        check("join", storage_join, 1'b1);
        check("bat_low", battery_low, 1'b0);
        volts(500, 3600, 3600);
        check("reg", main_output_reg, 1'b1);
        check("aux_reg", aux_output_reg, 3'h7);
        volts(500, 4200, 4200);
        check("conv", converter_en, 1'b0);
        volts(500, 4050, 4050);
        check("conv", converter_en, 1'b0);
        volts(500, 3100, 3100);
        check("conv", converter_en, 1'b1);
        check("reg", main_output_reg, 1'b0);
        aux_off_cfg = 3'h5;
        aux_gnd_off_cfg = 3'h2;
        step(2);
        check("aux", aux_output_en, 3'h2);
        check("aux_gnd", aux_gnd_en, 3'h5);
        aux_off_cfg = 3'h0;
        aux_gnd_off_cfg = 3'h0;
    endtask : t_normal
    task automatic t_sleep();
        sleep_req = 1'b1;
        wait_mode(pwr_seq_pkg::ST_SLEEP, 10);
        sleep_req = 1'b0;
        step(1);
        check("main", main_output_en, 1'b0);
        check("aux", aux_output_en, 3'h0);
        wake_up = 1'b1;
        wait_mode(pwr_seq_pkg::ST_NORMAL, 10);
        wake_up = 1'b0;
        step(1);
        check("main", main_output_en, 1'b1);
        timed_wake_en = 1'b1;
        wake_interval = 32'h0000_0014;
        sleep_req = 1'b1;
        wait_mode(pwr_seq_pkg::ST_SLEEP, 10);
        sleep_req = 1'b0;
        wait_mode(pwr_seq_pkg::ST_NORMAL, 40);
        check("wake_late", n >= 18, 1'b1);
    endtask : t_sleep
    task automatic t_warn();
        l = 2000;
        wait_mode(pwr_seq_pkg::ST_WARN, 10);
        step(1);
        check("bat_low", battery_low, 1'b1);
        check("main", main_output_en, 1'b1);
        wait_mode(pwr_seq_pkg::ST_PROTECT, 20);
        check("warn_len", n >= 6, 1'b1);
        step(1);
        check("join", storage_join, 1'b0);
    endtask : t_warn
    task automatic t_charged();
        h = 500;
        s = 3600;
        l = 3600;
        do_reset();
        wait_mode(pwr_seq_pkg::ST_NORMAL, 20);
        step(1);
        check("join", storage_join, 1'b1);
        check("main", main_output_en, 1'b1);
        check("reg", main_output_reg, 1'b1);
    endtask : t_charged
    task automatic t_sleep_prot();
        sleep_req = 1'b1;
        wait_mode(pwr_seq_pkg::ST_SLEEP, 10);
        sleep_req = 1'b0;
        l = 2000;
        wait_mode(pwr_seq_pkg::ST_PROTECT, 10);
        step(1);
        check("bat_low", battery_low, 1'b1);
        check("join", storage_join, 1'b0);
        check("main", main_output_en, 1'b1);
        volts(500, 1000, 2000);
        wait_mode(pwr_seq_pkg::ST_COLD, 10);
        check("main", main_output_en, 1'b0);
        check("track", tracking_en, 1'b0);
    endtask : t_sleep_prot
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        {wake_up, sleep_req, timed_wake_en} = 3'h0;
        wake_interval = 32'h0;
        {aux_off_cfg, aux_gnd_off_cfg} = 6'h0;
        {h, s, l, errors, checked} = '0;
        do_reset();
        t_reset();
        t_cold_start();
        t_normal();
        t_sleep();
        t_warn();
        t_charged();
        t_sleep_prot();
        conclude();
    end
endmodule : power_path_seq_tb_top
`default_nettype wire
